// ---- verilog/rsm_pkg.sv ----
// package: constants, modes and carrier types of the radio serial slave and mode control
package rsm_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned HDR_DIR_BIT = 7;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NUM_REGS = 64;
  localparam int unsigned MIN_BURSTS = 3;
  localparam int unsigned BURST_BITS = 8;
  localparam int unsigned CLOCK_OUTPUT_PIN_EN_REG = 7;
  localparam int unsigned CLOCK_OUTPUT_PIN_EN_BIT = 9;
  localparam int unsigned PWR_REG = 12;
  localparam logic [15:0] PWR_NOMINAL = 16'h00BC;
  localparam logic [15:0] PWR_MAXIMUM = 16'h00FF;
  localparam int unsigned CMD_REG = 1;
  localparam logic [15:0] CMD_HIBERNATE = 16'h0001;
  localparam logic [15:0] CMD_DOZE = 16'h0002;
  localparam logic [15:0] CMD_RECEIVE = 16'h0004;
  localparam logic [15:0] CMD_TRANSMIT = 16'h0008;
  localparam int unsigned OFF_IDLE_MS = 10;
  localparam int unsigned HIB_IDLE_MS = 7;
  localparam int unsigned DOZE_IDLE_US = 300;
  localparam int unsigned RXTX_EN_US = 144;
  localparam int unsigned OFF_IDLE_CYC = OFF_IDLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned HIB_IDLE_CYC = HIB_IDLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned DOZE_IDLE_CYC = DOZE_IDLE_US * CLK_MHZ;
  localparam int unsigned RXTX_EN_CYC = RXTX_EN_US * CLK_MHZ;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    RSM_OFF = 3'b000,
    RSM_IDLE = 3'b001,
    RSM_WARM = 3'b011,
    RSM_RX = 3'b010,
    RSM_TX = 3'b110,
    RSM_HIB = 3'b111,
    RSM_DOZE = 3'b101
  } rsm_mode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } rsm_wr_s;
endpackage

// ---- verilog/rsm_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module rsm_fifo #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rp_reg];
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        mem_reg[wp_reg] <= in_data_i;
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) rp_reg <= rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- verilog/rsm_top.sv ----
// serial slave port and operating mode control of the radio transceiver
`timescale 1ns/1ps
module rsm_top
  import rsm_pkg::*;
#(
  parameter int unsigned OFF_CYC = rsm_pkg::OFF_IDLE_CYC,
  parameter int unsigned HIB_CYC = rsm_pkg::HIB_IDLE_CYC,
  parameter int unsigned DOZE_CYC = rsm_pkg::DOZE_IDLE_CYC,
  parameter int unsigned RXTX_CYC = rsm_pkg::RXTX_EN_CYC,
  parameter int unsigned CLOCK_OUTPUT_PIN_DIV = 125
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // serial port, sampled as synchronous inputs
  input wire logic cs_n_i,
  input wire logic serial_clock_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // mode control
  input wire logic wake_attention_n_i,
  input wire logic radio_sequence_trigger_i,
  input wire logic doze_timer_match_i,
  input wire logic clock_output_pin_slow_i,
  // status and outputs
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe_o,
  output logic irq_n_o,
  output logic irq_oe_o,
  output logic outputs_oe_o,
  output rsm_pkg::rsm_mode_e mode_o,
  output logic rx_on_o,
  output logic tx_on_o,
  output logic [1:0] tx_power_o,
  output logic frame_error_o
);
  import rsm_pkg::*;
  localparam int unsigned TW = 32;

  //////////////////////////////////////////////////////////////////////////////
  // serial edge detection on the system clock
  logic sclk_d_reg;
  logic cs_d_reg;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= serial_clock_i;
      cs_d_reg <= cs_n_i;
    end
  end
  rsm_mode_e mode_reg;
  wire port_on = (mode_reg != RSM_OFF) && (mode_reg != RSM_HIB) && (mode_reg != RSM_DOZE);
  // core domain moves only while the port is on, so not in doze although the oscillator runs
  wire core_en = port_on;
  logic [WORD_W-1:0] regs_reg [NUM_REGS];
  wire sel = !cs_n_i && port_on;
  wire cs_fall = cs_d_reg && !cs_n_i;
  wire cs_rise = !cs_d_reg && cs_n_i;
  wire sclk_rise = sel && serial_clock_i && !sclk_d_reg;
  wire sclk_fall = sel && !serial_clock_i && sclk_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // burst shifting
  logic [7:0] rx_sh_reg;
  logic [2:0] bit_reg;
  logic [7:0] byte_cnt_reg;
  logic dir_rd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] hi_byte_reg;
  logic [7:0] tx_sh_reg;
  logic live_reg;
  wire [7:0] rx_byte = {rx_sh_reg[6:0], mosi_i};
  wire byte_done = sclk_rise && (bit_reg == 3'd7);
  wire is_hdr = (byte_cnt_reg == 8'd0);
  wire low_byte = byte_done && !is_hdr && !byte_cnt_reg[0];
  wire [WORD_W-1:0] rd_word;
  wire wr_fire = low_byte && !dir_rd_reg && live_reg;
  // reads walk forward one word per byte pair, like writes
  wire rd_next = low_byte && dir_rd_reg;
  wire [ADDR_W-1:0] addr_inc = addr_reg + 1'b1;
  wire [WORD_W-1:0] first_word = regs_reg[rx_byte[ADDR_W-1:0]];
  wire [WORD_W-1:0] next_word = regs_reg[addr_inc];
  wire fifo_ready;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || cs_fall || !sel) begin
      bit_reg <= '0;
      byte_cnt_reg <= '0;
      rx_sh_reg <= '0;
      live_reg <= sel || cs_fall;
    end else if (sclk_rise) begin
      rx_sh_reg <= rx_byte;
      bit_reg <= bit_reg + 3'd1;
      if (byte_done) begin
        byte_cnt_reg <= byte_cnt_reg + 8'd1;
        if (wr_fire && !fifo_ready) live_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      dir_rd_reg <= 1'b0;
      addr_reg <= '0;
      hi_byte_reg <= '0;
    end else if (byte_done && is_hdr) begin
      dir_rd_reg <= rx_byte[HDR_DIR_BIT];
      addr_reg <= rx_byte[ADDR_W-1:0];
    end else if (byte_done && byte_cnt_reg[0]) begin
      hi_byte_reg <= rx_byte;
    end else if (wr_fire || rd_next) begin
      addr_reg <= addr_inc; // sequential words both ways
    end
  end
  // read data shifts out on falling edges; miso stays low on write bursts
  wire load_hi = byte_done && dir_rd_reg && byte_cnt_reg[0];
  wire load_first = byte_done && is_hdr && rx_byte[HDR_DIR_BIT];
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !sel) begin
      tx_sh_reg <= '0;
    end else if (load_first) begin
      tx_sh_reg <= first_word[15:8];
    end else if (load_hi) begin
      tx_sh_reg <= rd_word[7:0];
    end else if (rd_next) begin
      tx_sh_reg <= next_word[15:8];
    end else if (sclk_fall && bit_reg != 3'd0) begin
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end
  // miso only carries data when the header asked for a read
  assign miso_o = tx_sh_reg[7] && dir_rd_reg && !is_hdr;
  assign miso_oe_o = sel;

  // frame check on release of chip select
  logic frame_err_reg;
  wire bad_frame = (byte_cnt_reg < 8'(MIN_BURSTS)) || !byte_cnt_reg[0] || (bit_reg != 3'd0);
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || cs_fall) frame_err_reg <= 1'b0;
    else if (cs_rise && port_on) frame_err_reg <= bad_frame;
  end
  assign frame_error_o = frame_err_reg;

  //////////////////////////////////////////////////////////////////////////////
  // write fifo toward the core register file
  rsm_wr_s fifo_in;
  rsm_wr_s fifo_out;
  logic fifo_valid;
  assign fifo_in = '{addr: addr_reg, data: {hi_byte_reg, rx_byte}};
  rsm_fifo #(.WIDTH($bits(rsm_wr_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_valid_i(wr_fire),
    .in_ready_o(fifo_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_valid),
    .out_ready_i(core_en),
    .out_data_o(fifo_out)
  );
  wire core_wr = fifo_valid && core_en;
  wire cmd_wr = core_wr && (fifo_out.addr == ADDR_W'(CMD_REG));
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_REGS; i++) regs_reg[i] <= '0;
    end else if (core_wr) begin
      regs_reg[fifo_out.addr] <= fifo_out.data;
    end
  end
  function automatic logic [WORD_W-1:0] rd_word_at(input logic [ADDR_W-1:0] a);
    rd_word_at = regs_reg[a];
  endfunction
  assign rd_word = rd_word_at(addr_reg);
  wire [WORD_W-1:0] pwr_word = regs_reg[PWR_REG];
  assign tx_power_o = (pwr_word == PWR_MAXIMUM) ? 2'd2 :
                      (pwr_word == PWR_NOMINAL) ? 2'd1 : 2'd0;

  //////////////////////////////////////////////////////////////////////////////
  // operating modes
  logic [TW-1:0] tmr_reg;
  logic trig_d_reg;
  logic pend_rx_reg;
  wire trig_rise = radio_sequence_trigger_i && !trig_d_reg;
  wire tmr_zero = (tmr_reg == '0);
  rsm_mode_e mode_next;
  logic [TW-1:0] tmr_next;
  always_comb begin
    mode_next = mode_reg;
    tmr_next = tmr_zero ? tmr_reg : tmr_reg - 1'b1;
    unique case (mode_reg)
      RSM_OFF: if (tmr_zero) mode_next = RSM_IDLE;
      RSM_IDLE: begin
        if (cmd_wr && fifo_out.data == CMD_HIBERNATE) begin
          mode_next = RSM_HIB;
        end else if (cmd_wr && fifo_out.data == CMD_DOZE) begin
          mode_next = RSM_DOZE;
        end else if (trig_rise) begin
          mode_next = RSM_WARM;
          tmr_next = TW'(RXTX_CYC);
        end
      end
      RSM_WARM: begin
        if (!radio_sequence_trigger_i) mode_next = RSM_IDLE;
        else if (tmr_zero) mode_next = pend_rx_reg ? RSM_RX : RSM_TX;
      end
      RSM_RX, RSM_TX: if (!radio_sequence_trigger_i) mode_next = RSM_IDLE;
      RSM_HIB: begin
        // load once; a held attention level must not restart the count
        if (!wake_attention_n_i && tmr_zero) tmr_next = TW'(HIB_CYC);
        if (tmr_reg == TW'(1)) mode_next = RSM_IDLE;
      end
      RSM_DOZE: begin
        if ((!wake_attention_n_i || doze_timer_match_i) && tmr_zero) begin
          tmr_next = TW'(DOZE_CYC);
        end
        if (tmr_reg == TW'(1)) mode_next = RSM_IDLE;
      end
      default: mode_next = RSM_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_reg <= RSM_OFF;
      tmr_reg <= TW'(OFF_CYC);
      trig_d_reg <= 1'b0;
      pend_rx_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      tmr_reg <= tmr_next;
      trig_d_reg <= radio_sequence_trigger_i;
      if (cmd_wr && fifo_out.data == CMD_RECEIVE) pend_rx_reg <= 1'b1;
      if (cmd_wr && fifo_out.data == CMD_TRANSMIT) pend_rx_reg <= 1'b0;
    end
  end
  assign mode_o = mode_reg;
  assign rx_on_o = (mode_reg == RSM_RX);
  assign tx_on_o = (mode_reg == RSM_TX);

  //////////////////////////////////////////////////////////////////////////////
  // clock output divider; oscillator stops in hibernate
  logic [15:0] div_reg;
  logic clock_output_pin_reg;
  wire osc_on = (mode_reg != RSM_OFF) && (mode_reg != RSM_HIB);
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !osc_on) begin
      div_reg <= '0;
      clock_output_pin_reg <= 1'b0;
    end else if (div_reg == 16'(CLOCK_OUTPUT_PIN_DIV - 1)) begin
      div_reg <= '0;
      clock_output_pin_reg <= !clock_output_pin_reg;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end
  wire clock_output_pin_en_bit = regs_reg[CLOCK_OUTPUT_PIN_EN_REG][CLOCK_OUTPUT_PIN_EN_BIT];
  wire clock_output_pin_allowed = (mode_reg == RSM_DOZE) ? (clock_output_pin_en_bit && clock_output_pin_slow_i) : osc_on;
  assign clock_output_pin_o = clock_output_pin_reg && clock_output_pin_allowed;
  assign clock_output_pin_oe_o = clock_output_pin_allowed;
  assign outputs_oe_o = (mode_reg != RSM_OFF);
  assign irq_oe_o = (mode_reg != RSM_OFF);
  assign irq_n_o = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  mode_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode_reg == RSM_OFF) |-> !irq_oe_o && !miso_oe_o && !clock_output_pin_oe_o)
    else $error("output driven in off mode");
  lp_miso_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode_reg == RSM_HIB || mode_reg == RSM_DOZE) |-> !miso_oe_o)
    else $error("serial port active in low power mode");
  desel_miso_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cs_n_i |-> !miso_oe_o)
    else $error("miso driven while deselected");
  trig_idle_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!radio_sequence_trigger_i && (mode_reg == RSM_RX || mode_reg == RSM_TX))
    |=> mode_reg == RSM_IDLE)
    else $error("trigger low did not force idle");
  warm_start_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode_reg == RSM_IDLE && mode_next == RSM_WARM) |=> tmr_reg == TW'(RXTX_CYC))
    else $error("warm up not loaded with enable time");
  write_only_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!dir_rd_reg || is_hdr) |-> !miso_o)
    else $error("miso active during write burst");
  power_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (pwr_word == PWR_MAXIMUM) |-> tx_power_o == 2'd2)
    else $error("power code not decoded");
  doze_clock_output_pin_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (mode_reg == RSM_DOZE && !clock_output_pin_en_bit) |-> !clock_output_pin_oe_o)
    else $error("clock output in doze without enable");
  hdr_latch_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (byte_done && is_hdr) |=> dir_rd_reg == $past(rx_byte[HDR_DIR_BIT]))
    else $error("direction not taken from header");
  rd_step_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_next |=> addr_reg == $past(addr_inc))
    else $error("read address did not advance");
  rd_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) rd_next);
  rx_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) mode_reg == RSM_RX);
  wr_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) core_wr);
  hib_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    mode_reg == RSM_HIB ##1 mode_reg == RSM_IDLE);
endmodule

// ---- tb/rsm_host.sv ----
// host master model driving the serial port in mode 0
`timescale 1ns/1ps
module rsm_host (
  // clock
  input wire logic clk_sys_i,
  // serial port
  output logic cs_n_o,
  output logic sclk_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  // clock stands low outside frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // five system cycles per phase keeps the synchronous sampler safe
  task automatic start();
    @(negedge clk_sys_i);
    cs_n_o = 1'b0;
    repeat (5) @(negedge clk_sys_i);
  endtask
  task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      repeat (5) @(negedge clk_sys_i);
      // a floating line is seen as the inverse of its last level
      r[i] = miso_oe_i ? miso_i : ~miso_i;
      sclk_o = 1'b1;
      repeat (5) @(negedge clk_sys_i);
      sclk_o = 1'b0;
    end
  endtask
  task automatic stop();
    repeat (5) @(negedge clk_sys_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (10) @(negedge clk_sys_i);
  endtask
endmodule

// ---- tb/tb.sv ----
// self-checking testbench of the serial slave and mode control
`timescale 1ns/1ps
module tb;
  import rsm_pkg::*;
  localparam int OFF_C = 50;
  localparam int HIB_C = 40;
  localparam int DOZE_C = 30;
  localparam int RXTX_C = 50;
  localparam int DIV = 4;
  logic clk_sys_i = 1'b0;
  logic reset_i, cs_n, sclk, mosi, miso_o, miso_oe_o;
  logic wake_n, trig, tmatch, slow;
  logic clk_out, clk_out_oe, irq_n, irq_oe, outputs_oe_o, rx_on, tx_on, frame_error_o;
  logic [1:0] tx_power;
  rsm_mode_e mode_o;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  logic [7:0] r;
  ////////////////////////////////////////////////////////////////////////
  always #2 clk_sys_i = ~clk_sys_i;
  rsm_top #(.OFF_CYC(OFF_C), .HIB_CYC(HIB_C), .DOZE_CYC(DOZE_C), .RXTX_CYC(RXTX_C),
    .CLOCK_OUTPUT_PIN_DIV(DIV)) rsm_top_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cs_n_i(cs_n),
    .serial_clock_i(sclk), .mosi_i(mosi), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .wake_attention_n_i(wake_n), .radio_sequence_trigger_i(trig),
    .doze_timer_match_i(tmatch), .clock_output_pin_slow_i(slow), .clock_output_pin_o(clk_out),
    .clock_output_pin_oe_o(clk_out_oe), .irq_n_o(irq_n), .irq_oe_o(irq_oe),
    .outputs_oe_o(outputs_oe_o), .mode_o(mode_o), .rx_on_o(rx_on), .tx_on_o(tx_on),
    .tx_power_o(tx_power), .frame_error_o(frame_error_o));
  rsm_host rsm_host_inst (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .sclk_o(sclk),
    .mosi_o(mosi), .miso_i(miso_o), .miso_oe_i(miso_oe_o));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a frame while asleep sees a floating line, so its header is not compared
  task automatic wr(input logic [5:0] a, input logic [15:0] d [$], input bit hdr_chk);
    logic [7:0] q;
    rsm_host_inst.start();
    rsm_host_inst.xbyte({2'b00, a}, q);
    if (hdr_chk) chk({8'h00, q}, 16'h0000);
    foreach (d[i]) begin
      rsm_host_inst.xbyte(d[i][15:8], q);
      rsm_host_inst.xbyte(d[i][7:0], q);
    end
    rsm_host_inst.stop();
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e [$]);
    logic [7:0] h;
    logic [7:0] l;
    rsm_host_inst.start();
    rsm_host_inst.xbyte({2'b10, a}, h);
    foreach (e[i]) begin
      rsm_host_inst.xbyte(8'h00, h);
      rsm_host_inst.xbyte(8'h00, l);
      chk({h, l}, e[i]);
    end
    rsm_host_inst.stop();
  endtask
  task automatic wait_mode(input rsm_mode_e m, input int lim, output int c);
    c = 0;
    while (mode_o !== m && c < lim) begin
      @(negedge clk_sys_i);
      c++;
    end
  endtask
  task automatic in_rng(input int c, input int lo, input int hi);
    chk(16'(c >= lo && c <= hi), 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    final_report();
  end
  initial begin
    reset_i = 1'b1;
    wake_n = 1'b1;
    trig = 1'b0;
    tmatch = 1'b0;
    slow = 1'b1;
    repeat (6) @(negedge clk_sys_i);
    chk({12'h000, outputs_oe_o, irq_oe, miso_oe_o, clk_out_oe}, 16'h0000);
    chk({13'h0000, mode_o}, {13'h0000, RSM_OFF});
    reset_i = 1'b0;
    wait_mode(RSM_IDLE, OFF_C + 20, n);
    in_rng(n, OFF_C - 2, OFF_C + 3);
    chk({12'h000, outputs_oe_o, clk_out_oe, irq_oe, irq_n}, 16'h000F);
    n = 0;
    repeat (2 * DIV) begin
      @(negedge clk_sys_i);
      n += int'(clk_out);
    end
    chk(16'(n), 16'(DIV));
    $display("reset test done");
    wr(6'(PWR_REG), '{PWR_NOMINAL}, 1'b1);
    chk({14'h0000, tx_power}, 16'h0001);
    wr(6'(PWR_REG), '{PWR_MAXIMUM}, 1'b1);
    chk({14'h0000, tx_power}, 16'h0002);
    rd_chk(6'(PWR_REG), '{PWR_MAXIMUM});
    wr(6'd20, '{16'hA55A, 16'h0FF0, 16'h8001}, 1'b1);
    rd_chk(6'd20, '{16'hA55A, 16'h0FF0, 16'h8001});
    chk({15'h0000, frame_error_o}, 16'h0000);
    chk({15'h0000, miso_oe_o}, 16'h0000);
    $display("register test done");
    rsm_host_inst.start();
    rsm_host_inst.xbyte(8'h1E, r);
    rsm_host_inst.xbyte(8'h5A, r);
    rsm_host_inst.stop();
    chk({15'h0000, frame_error_o}, 16'h0001);
    wr(6'd31, '{16'h1234}, 1'b1);
    chk({15'h0000, frame_error_o}, 16'h0000);
    $display("framing test done");
    for (int k = 0; k < 2; k++) begin
      wr(6'(CMD_REG), '{k ? CMD_TRANSMIT : CMD_RECEIVE}, 1'b1);
      trig = 1'b1;
      wait_mode(k ? RSM_TX : RSM_RX, RXTX_C + 20, n);
      in_rng(n, RXTX_C - 2, RXTX_C + 3);
      chk({14'h0000, rx_on, tx_on}, k ? 16'h0001 : 16'h0002);
      trig = 1'b0;
      wait_mode(RSM_IDLE, 10, n);
      in_rng(n, 0, 3);
    end
    $display("sequence test done");
    wr(6'(CMD_REG), '{CMD_HIBERNATE}, 1'b1);
    chk({13'h0000, mode_o}, {13'h0000, RSM_HIB});
    wr(6'(PWR_REG), '{PWR_NOMINAL}, 1'b0);
    chk({14'h0000, tx_power}, 16'h0002);
    wake_n = 1'b0;
    wait_mode(RSM_IDLE, HIB_C + 20, n);
    in_rng(n, HIB_C - 2, HIB_C + 3);
    wake_n = 1'b1;
    rd_chk(6'(PWR_REG), '{PWR_MAXIMUM});
    $display("hibernate test done");
    wr(6'(CLOCK_OUTPUT_PIN_EN_REG), '{16'h0200}, 1'b1);
    // slow clock with the enable drives the pin in doze, a fast one does not
    for (int k = 0; k < 2; k++) begin
      slow = k ? 1'b0 : 1'b1;
      wr(6'(CMD_REG), '{CMD_DOZE}, 1'b1);
      chk({13'h0000, mode_o}, {13'h0000, RSM_DOZE});
      chk({15'h0000, clk_out_oe}, k ? 16'h0000 : 16'h0001);
      if (k) wake_n = 1'b0;
      else tmatch = 1'b1;
      wait_mode(RSM_IDLE, DOZE_C + 30, n);
      in_rng(n, DOZE_C - 2, DOZE_C + 2 * DIV + 3);
      wake_n = 1'b1;
      tmatch = 1'b0;
    end
    $display("doze test done");
    final_report();
  end
endmodule
